//--- core/event_flags.sv
`timescale 1ns/1ps
`default_nettype none

module event_flags #(
    parameter int WIDTH = 3
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] set,
    input wire logic [WIDTH-1:0] clr,
    input wire logic [WIDTH-1:0] mask,
    output logic [WIDTH-1:0] flags,
    output logic irq
);

    typedef struct packed {
        logic [WIDTH-1:0] flags;
    } flag_state_t;

    flag_state_t f_reg;
    flag_state_t f_next;

    // set wins over a clear in the same cycle so no event is lost
    always_comb
    begin
        f_next.flags = (f_reg.flags & ~clr) | set;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            f_reg <= '0;
        else
            f_reg <= f_next;
    end

    assign flags = f_reg.flags;
    assign irq = |(f_reg.flags & mask);

endmodule : event_flags

`default_nettype wire

//--- core/sync2.sv
`timescale 1ns/1ps
`default_nettype none

module sync2 #(
    parameter int WIDTH = 1
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_state_t;

    sync_state_t s_reg;
    sync_state_t s_next;

    // first stage feeds only the second stage
    always_comb
    begin
        s_next.meta = d;
        s_next.stable = s_reg.meta;
    end

    // bus lines idle high, so reset to ones
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            s_reg <= '1;
        else
            s_reg <= s_next;
    end

    assign q = s_reg.stable;

endmodule : sync2

`default_nettype wire

//--- core/twowire_master_transmit_ctrl.sv
// Summary of operation
// [RQ1] after START report 08, send address byte
// [RQ2] after repeated START report 10, transmit
// [RQ3] address-plus-read after 10 hands to receiver
// [RQ4] address acked 18, not acked 20
// [RQ5] data acked 28, not acked 30
// [RQ6] 18-30, no requests: send next byte
// [RQ7] 18-30, start only: repeated START
// [RQ8] 18-30, stop only: STOP, clear stop
// [RQ9] 18-30, both: STOP, START, clear stop
// [RQ10] arbitration lost on address/data reports 38
// [RQ11] 38, no start: release, not addressed
// [RQ12] 38 with start: START once bus free
// [RQ13] software starts with start and enable
// [RQ14] flag sets after START, bus paused
// [RQ15] pause until flag cleared by one
// [RQ16] status stable while flag set, ack ignored
//
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none

module twowire_master_transmit_ctrl
    import twowire_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [7:0] rdata,
    output logic irq,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe,
    output logic master_rx_mode
);

    typedef struct packed {
        phase_t phase;
        logic [15:0] cnt;
        logic [7:0] shift_data;
        logic [3:0] bit_idx;
        logic completion_flag;
        logic ack_enable;
        logic start_request;
        logic stop_request;
        logic interface_enable;
        logic [7:0] code;
        logic addr_phase;
        logic rd_byte;
        logic repeat_start;
        logic scl_low;
        logic sda_low;
        logic busy;
        logic sda_d;
        logic rx_mode;
        logic [2:0] irq_mask;
        logic [7:0] rdata;
    } ctl_state_t;

    ctl_state_t s_reg;
    ctl_state_t s_next;

    logic scl_s;
    logic sda_s;
    logic ev_done;
    logic ev_arb;
    logic ev_nack;
    logic [IRQ_WIDTH-1:0] irq_clr;
    logic [IRQ_WIDTH-1:0] irq_flags;
    logic [7:0] ctl_view;

    // pins come from another domain: two flops before any use
    sync2 #(
        .WIDTH(2)
    ) u_pin_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({scl_in, sda_in}),
        .q({scl_s, sda_s})
    );

    // write-one-to-clear for the interrupt status register
    assign irq_clr = (wr_en && addr == ADDR_IRQ_STATUS)
        ? wdata[IRQ_WIDTH-1:0] : '0;

    event_flags #(
        .WIDTH(IRQ_WIDTH)
    ) u_events (
        .clk(clk),
        .rst_n(rst_n),
        .set({ev_nack, ev_arb, ev_done}),
        .clr(irq_clr),
        .mask(s_reg.irq_mask),
        .flags(irq_flags),
        .irq(irq)
    );

    // control register as software sees it
    always_comb
    begin
        ctl_view = 8'h00;
        ctl_view[CTL_FLAG_BIT] = s_reg.completion_flag;
        ctl_view[CTL_ACKEN_BIT] = s_reg.ack_enable;
        ctl_view[CTL_START_BIT] = s_reg.start_request;
        ctl_view[CTL_STOP_BIT] = s_reg.stop_request;
        ctl_view[CTL_EN_BIT] = s_reg.interface_enable;
    end

    // register access first, then the bus sequencer may override it
    always_comb
    begin
        s_next = s_reg;
        ev_done = 1'b0;
        ev_arb = 1'b0;
        ev_nack = 1'b0;
        s_next.sda_d = sda_s;
        if (s_reg.cnt != 16'h0000)
            s_next.cnt = s_reg.cnt - 16'h0001;

        // bus busy between any START and STOP seen on the wire
        if (scl_s && s_reg.sda_d && !sda_s)
            s_next.busy = 1'b1;
        else if (scl_s && !s_reg.sda_d && sda_s)
            s_next.busy = 1'b0;

        // read data valid the cycle after the strobe only
        s_next.rdata = 8'h00;
        if (rd_en)
        begin
            case (addr)
                ADDR_CONTROL: s_next.rdata = ctl_view;
                ADDR_STATUS: s_next.rdata = s_reg.completion_flag
                    ? s_reg.code : CODE_NO_INFO; // RQ16
                ADDR_DATA: s_next.rdata = s_reg.shift_data;
                ADDR_IRQ_STATUS: s_next.rdata = {5'h00, irq_flags};
                ADDR_IRQ_MASK: s_next.rdata = {5'h00, s_reg.irq_mask};
                default: s_next.rdata = 8'h00;
            endcase
        end

        // software writes; ack_enable is stored but never used here
        if (wr_en)
        begin
            case (addr)
                ADDR_CONTROL:
                begin
                    s_next.ack_enable = wdata[CTL_ACKEN_BIT]; // RQ16
                    s_next.start_request = wdata[CTL_START_BIT]; // RQ13
                    s_next.stop_request = wdata[CTL_STOP_BIT];
                    s_next.interface_enable = wdata[CTL_EN_BIT]; // RQ13
                    if (wdata[CTL_FLAG_BIT])
                        s_next.completion_flag = 1'b0; // RQ15
                end
                ADDR_DATA:
                begin
                    // writes while the bus is moving would corrupt the shift
                    if (s_reg.completion_flag)
                        s_next.shift_data = wdata;
                end
                ADDR_IRQ_MASK: s_next.irq_mask = wdata[IRQ_WIDTH-1:0];
                default: ;
            endcase
        end

        // bus sequencer
        case (s_reg.phase)
            PH_IDLE:
            begin
                s_next.scl_low = 1'b0;
                s_next.sda_low = 1'b0;
                if (s_reg.interface_enable && s_reg.start_request &&
                    !s_reg.completion_flag)
                begin
                    s_next.repeat_start = 1'b0;
                    s_next.phase = PH_WAIT_FREE; // RQ13
                end
            end
            PH_WAIT_FREE:
            begin
                // only claim the bus when both lines are seen idle
                if (!s_reg.busy && scl_s && sda_s)
                begin
                    s_next.sda_low = 1'b1; // RQ12
                    s_next.cnt = HALF_COUNT;
                    s_next.phase = PH_START_HOLD;
                end
            end
            PH_START_HOLD:
            begin
                if (s_reg.cnt == 16'h0000)
                begin
                    s_next.scl_low = 1'b1; // RQ14
                    s_next.code = s_reg.repeat_start
                        ? CODE_RSTART : CODE_START; // RQ1 RQ2
                    s_next.completion_flag = 1'b1; // RQ14
                    ev_done = 1'b1;
                    s_next.phase = PH_PAUSE;
                end
            end
            PH_PAUSE:
            begin
                // clock held low (released after lost arbitration) and code frozen until the flag clears
                if (!s_reg.completion_flag)
                begin // RQ15
                    case (s_reg.code)
                        CODE_START, CODE_RSTART:
                        begin
                            s_next.addr_phase = 1'b1; // RQ1 RQ2
                            s_next.rd_byte = (s_reg.code == CODE_RSTART) &&
                                s_reg.shift_data[0]; // RQ3
                            s_next.bit_idx = 4'h0;
                            s_next.cnt = HALF_COUNT;
                            s_next.phase = PH_BIT_LOW;
                        end
                        CODE_ADDR_ACK, CODE_ADDR_NACK,
                        CODE_DATA_ACK, CODE_DATA_NACK:
                        begin
                            s_next.cnt = HALF_COUNT;
                            if (s_reg.stop_request)
                                s_next.phase = PH_STOP1; // RQ8 RQ9
                            else if (s_reg.start_request)
                                s_next.phase = PH_RSTART1; // RQ7
                            else
                            begin
                                s_next.addr_phase = 1'b0; // RQ6
                                s_next.rd_byte = 1'b0;
                                s_next.bit_idx = 4'h0;
                                s_next.phase = PH_BIT_LOW;
                            end
                        end
                        CODE_ARB_LOST:
                        begin
                            s_next.scl_low = 1'b0;
                            s_next.sda_low = 1'b0;
                            s_next.repeat_start = 1'b0;
                            if (s_reg.start_request)
                                s_next.phase = PH_WAIT_FREE; // RQ12
                            else
                                s_next.phase = PH_IDLE; // RQ11
                        end
                        default: s_next.phase = PH_IDLE;
                    endcase
                end
            end
            PH_BIT_LOW:
            begin
                s_next.scl_low = 1'b1;
                // move data mid-way through the low half for hold margin
                if (s_reg.cnt == SDA_CHANGE_COUNT)
                    s_next.sda_low = (s_reg.bit_idx != ACK_BIT_INDEX) &&
                        !s_reg.shift_data[7];
                if (s_reg.cnt == 16'h0000)
                begin
                    s_next.scl_low = 1'b0;
                    s_next.cnt = HALF_COUNT;
                    s_next.phase = PH_BIT_HIGH;
                end
            end
            PH_BIT_HIGH:
            begin
                // a slave stretching the clock holds the count
                if (!scl_s)
                    s_next.cnt = s_reg.cnt;
                else if (s_reg.bit_idx != ACK_BIT_INDEX &&
                    !s_reg.sda_low && !sda_s)
                begin
                    // another master pulled the line we released
                    s_next.scl_low = 1'b0;
                    s_next.sda_low = 1'b0;
                    s_next.code = CODE_ARB_LOST; // RQ10
                    s_next.completion_flag = 1'b1;
                    ev_done = 1'b1;
                    ev_arb = 1'b1;
                    s_next.phase = PH_PAUSE;
                end
                else if (s_reg.cnt == 16'h0000)
                begin
                    s_next.scl_low = 1'b1;
                    s_next.cnt = HALF_COUNT;
                    if (s_reg.bit_idx == ACK_BIT_INDEX)
                    begin
                        if (s_reg.rd_byte)
                        begin
                            s_next.rx_mode = 1'b1; // RQ3
                            s_next.phase = PH_RX_MODE;
                        end
                        else
                        begin
                            if (s_reg.addr_phase)
                                s_next.code = sda_s
                                    ? CODE_ADDR_NACK : CODE_ADDR_ACK; // RQ4
                            else
                                s_next.code = sda_s
                                    ? CODE_DATA_NACK : CODE_DATA_ACK; // RQ5
                            s_next.completion_flag = 1'b1;
                            ev_done = 1'b1;
                            ev_nack = sda_s;
                            s_next.phase = PH_PAUSE;
                        end
                    end
                    else
                    begin
                        s_next.shift_data = {s_reg.shift_data[6:0],
                            s_reg.shift_data[7]};
                        s_next.bit_idx = s_reg.bit_idx + 4'h1;
                        s_next.phase = PH_BIT_LOW;
                    end
                end
            end
            PH_RSTART1:
            begin
                // release data while the clock is low, then raise clock
                s_next.sda_low = 1'b0;
                if (s_reg.cnt == 16'h0000)
                begin
                    s_next.scl_low = 1'b0;
                    s_next.cnt = HALF_COUNT;
                    s_next.phase = PH_RSTART2;
                end
            end
            PH_RSTART2:
            begin
                if (!scl_s)
                    s_next.cnt = s_reg.cnt;
                else if (s_reg.cnt == 16'h0000)
                begin
                    s_next.repeat_start = 1'b1; // RQ7
                    s_next.sda_low = 1'b1;
                    s_next.cnt = HALF_COUNT;
                    s_next.phase = PH_START_HOLD;
                end
            end
            PH_STOP1:
            begin
                s_next.sda_low = 1'b1;
                if (s_reg.cnt == 16'h0000)
                begin
                    s_next.scl_low = 1'b0;
                    s_next.cnt = HALF_COUNT;
                    s_next.phase = PH_STOP2;
                end
            end
            PH_STOP2:
            begin
                if (!scl_s)
                    s_next.cnt = s_reg.cnt;
                else if (s_reg.cnt == 16'h0000)
                begin
                    s_next.sda_low = 1'b0; // RQ8
                    s_next.cnt = HALF_COUNT;
                    s_next.phase = PH_STOP3;
                end
            end
            PH_STOP3:
            begin
                // hardware clear beats a same-cycle software write
                if (s_reg.cnt == 16'h0000)
                begin
                    s_next.stop_request = 1'b0; // RQ8 RQ9
                    s_next.repeat_start = 1'b0;
                    if (s_next.start_request)
                        s_next.phase = PH_WAIT_FREE; // RQ9
                    else
                        s_next.phase = PH_IDLE;
                end
            end
            PH_RX_MODE:
            begin
                // receiver logic lives elsewhere; clock held low meanwhile
                s_next.scl_low = 1'b1;
                s_next.sda_low = 1'b0;
            end
            default: s_next.phase = PH_IDLE;
        endcase

        // disabling the interface abandons the bus at once
        if (!s_next.interface_enable)
        begin
            s_next.phase = PH_IDLE;
            s_next.scl_low = 1'b0;
            s_next.sda_low = 1'b0;
            s_next.rx_mode = 1'b0;
            s_next.completion_flag = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            s_reg <= '0;
            s_reg.phase <= PH_IDLE;
            s_reg.shift_data <= DATA_RESET;
            s_reg.code <= CODE_RESET;
            s_reg.sda_d <= 1'b1;
            s_reg.irq_mask <= MASK_RESET;
        end
        else
            s_reg <= s_next;
    end

    // open drain: only ever drive low
    assign scl_out = 1'b0;
    assign sda_out = 1'b0;
    assign scl_oe = s_reg.scl_low;
    assign sda_oe = s_reg.sda_low;
    assign rdata = s_reg.rdata;
    assign master_rx_mode = s_reg.rx_mode;

endmodule : twowire_master_transmit_ctrl

`default_nettype wire

//--- shared/twowire_pkg.sv
package twowire_pkg;

    // timing: bus half period derived from the system clock rate
    localparam int CLK_PERIOD_NS = 10;
    localparam int BUS_HALF_NS = 5000;
    localparam int HALF_CYCLES = (BUS_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [15:0] HALF_COUNT = 16'(HALF_CYCLES - 1);
    localparam logic [15:0] SDA_CHANGE_COUNT = 16'(HALF_CYCLES / 2);

    // register addresses
    localparam logic [2:0] ADDR_CONTROL = 3'h0;
    localparam logic [2:0] ADDR_STATUS = 3'h1;
    localparam logic [2:0] ADDR_DATA = 3'h2;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h3;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h4;

    // control register fields
    localparam int CTL_FLAG_BIT = 7;
    localparam int CTL_ACKEN_BIT = 6;
    localparam int CTL_START_BIT = 5;
    localparam int CTL_STOP_BIT = 4;
    localparam int CTL_EN_BIT = 2;

    // interrupt status / mask fields
    localparam int IRQ_WIDTH = 3;
    localparam int IRQ_DONE_BIT = 0;
    localparam int IRQ_ARB_BIT = 1;
    localparam int IRQ_NACK_BIT = 2;

    // status codes
    localparam logic [7:0] CODE_START = 8'h08;
    localparam logic [7:0] CODE_RSTART = 8'h10;
    localparam logic [7:0] CODE_ADDR_ACK = 8'h18;
    localparam logic [7:0] CODE_ADDR_NACK = 8'h20;
    localparam logic [7:0] CODE_DATA_ACK = 8'h28;
    localparam logic [7:0] CODE_DATA_NACK = 8'h30;
    localparam logic [7:0] CODE_ARB_LOST = 8'h38;
    localparam logic [7:0] CODE_NO_INFO = 8'hf8;

    // reset values and ack bit index
    localparam logic [7:0] DATA_RESET = 8'hff;
    localparam logic [7:0] CODE_RESET = 8'hf8;
    localparam logic [2:0] MASK_RESET = 3'h0;
    localparam logic [3:0] ACK_BIT_INDEX = 4'h8;

    typedef enum logic [3:0] {
        PH_IDLE = 4'b0000,
        PH_WAIT_FREE = 4'b0001,
        PH_START_HOLD = 4'b0010,
        PH_PAUSE = 4'b0011,
        PH_BIT_LOW = 4'b0100,
        PH_BIT_HIGH = 4'b0101,
        PH_RSTART1 = 4'b0110,
        PH_RSTART2 = 4'b0111,
        PH_STOP1 = 4'b1000,
        PH_STOP2 = 4'b1001,
        PH_STOP3 = 4'b1010,
        PH_RX_MODE = 4'b1011
    } phase_t;

endpackage : twowire_pkg

//--- sim/twowire_master_transmit_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module twowire_master_transmit_ctrl_tb_top
    import twowire_pkg::*;
;
    logic clk, rst_n, wr_en, rd_en, irq, ack, arb, pull;
    logic scl_out, scl_oe, sda_out, sda_oe, master_rx_mode;
    logic scl_w, sda_w;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, rx_byte, v, data_byte;
    logic [7:0] exp_q[$];
    int n_mismatch = 0;
    int checks_done = 0;
    int since_start = 0;

    // pull-ups on both wires
    assign scl_w = scl_oe ? scl_out : 1'b1;
    assign sda_w = (sda_oe ? sda_out : 1'b1) & !pull;

    twowire_master_transmit_ctrl dut (
        .clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
        .scl_in(scl_w), .scl_out, .scl_oe,
        .sda_in(sda_w), .sda_out, .sda_oe, .master_rx_mode
    );
    twowire_slave_model slave (
        .scl(scl_w), .sda(sda_w), .ack(ack), .arb(arb),
        .sda_pull(pull), .rx_byte(rx_byte)
    );

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : final_report

    task automatic check8(input logic [7:0] got, exp);
        checks_done++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : check8

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_en <= 1'b1;
        @(posedge clk);
        wr_en <= 1'b0;
    endtask : wr

    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clk);
        rd_en <= 1'b0;
        #1 d = rdata;
    endtask : rd

    // bounded poll of one control bit
    task automatic poll(input int b, input logic val);
        rd(ADDR_CONTROL, v);
        for (int k = 0; k < 9000 && v[b] !== val; k++)
            rd(ADDR_CONTROL, v);
    endtask : poll

    task automatic start_seq(input logic [7:0] ctl, input logic [7:0] code);
        wr(ADDR_CONTROL, ctl);
        poll(CTL_FLAG_BIT, 1'b1);
        rd(ADDR_STATUS, v);
        check8(v, code);
        rd(ADDR_STATUS, v);
        check8(v, code);
        since_start = 0;
    endtask : start_seq

    // first byte after a start is the address
    task automatic send(input logic [7:0] b, input logic a);
        logic [7:0] code;
        code = a ? CODE_DATA_ACK : CODE_DATA_NACK;
        if (since_start == 0)
            code = a ? CODE_ADDR_ACK : CODE_ADDR_NACK;
        ack <= a;
        wr(ADDR_DATA, b);
        exp_q.push_back(b);
        wr(ADDR_CONTROL, 8'h84);
        rd(ADDR_STATUS, v);
        check8(v, CODE_NO_INFO);
        poll(CTL_FLAG_BIT, 1'b1);
        rd(ADDR_STATUS, v);
        check8(v, code);
        check8(rx_byte, exp_q.pop_front());
        since_start++;
    endtask : send

    // watchdog, run needs ~60k cycles
    initial
    begin
        #1_000_000;
        n_mismatch++;
        final_report();
    end

    initial
    begin
        rst_n = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        wr_en = 1'b0;
        rd_en = 1'b0;
        ack = 1'b0;
        arb = 1'b0;
        void'($urandom(22));
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        rd(ADDR_STATUS, v);
        check8(v, CODE_RESET);
        rd(ADDR_DATA, v);
        check8(v, DATA_RESET);
        rd(3'h7, v);
        check8(v, 8'h00);
        // ack, nack, then read hand-over
        wr(ADDR_IRQ_MASK, 8'h01);
        start_seq(8'h24, CODE_START);
        @(negedge clk);
        check8({7'h0, irq}, 8'h01);
        wr(ADDR_IRQ_STATUS, 8'h01);
        @(negedge clk);
        check8({7'h0, irq}, 8'h00);
        data_byte = 8'($urandom);
        send(8'ha0, 1'b1);
        send(data_byte, 1'b0);
        rd(ADDR_IRQ_STATUS, v);
        check8(v & 8'h04, 8'h04);
        start_seq(8'ha4, CODE_RSTART);
        ack <= 1'b1;
        wr(ADDR_DATA, 8'ha1);
        wr(ADDR_CONTROL, 8'h84);
        for (int i = 0; i < 12000 && master_rx_mode !== 1'b1; i++)
            @(posedge clk);
        check8({7'h0, master_rx_mode}, 8'h01);
        check8(rx_byte, 8'ha1);
        wr(ADDR_CONTROL, 8'h00);
        // second reset clears the busy bus
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // lost arbitration in the address byte
        start_seq(8'h24, CODE_START);
        arb <= 1'b1;
        wr(ADDR_DATA, 8'hc8);
        wr(ADDR_CONTROL, 8'h84);
        poll(CTL_FLAG_BIT, 1'b1);
        rd(ADDR_STATUS, v);
        check8(v, CODE_ARB_LOST);
        rd(ADDR_IRQ_STATUS, v);
        check8(v & 8'h02, 8'h02);
        wr(ADDR_CONTROL, 8'h84);
        repeat (10) @(posedge clk);
        check8({6'h0, scl_oe, sda_oe}, 8'h00);
        rd(ADDR_STATUS, v);
        check8(v, CODE_NO_INFO);
        arb <= 1'b0;
        repeat (10) @(posedge clk);
        // stop+start, nack address, data, stop
        start_seq(8'h24, CODE_START);
        send(8'ha0, 1'b1);
        start_seq(8'hb4, CODE_START);
        rd(ADDR_CONTROL, v);
        check8(v & 8'h30, 8'h20);
        send(8'ha0, 1'b0);
        send(data_byte ^ 8'h5a, 1'b1);
        wr(ADDR_CONTROL, 8'h94);
        poll(CTL_STOP_BIT, 1'b0);
        check8(v & 8'h10, 8'h00);
        repeat (600) @(posedge clk);
        check8({6'h0, scl_oe, sda_oe}, 8'h00);
        final_report();
    end
endmodule : twowire_master_transmit_ctrl_tb_top

bind twowire_master_transmit_ctrl twowire_properties chk (
    .clk, .rst_n, .addr, .wdata, .wr_en, .rd_en, .rdata, .irq,
    .scl_oe, .sda_oe, .master_rx_mode
);

`default_nettype wire

//--- sim/twowire_properties.sv
`timescale 1ns/1ps
`default_nettype none

module twowire_properties
    import twowire_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [7:0] rdata,
    input wire logic irq,
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic master_rx_mode
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    logic ctl_wr;
    logic [15:0] low_cnt;
    logic clr_seen, armed, rd_q, code_ok;
    logic [7:0] last_code;
    assign ctl_wr = wr_en && addr == ADDR_CONTROL;

    // helpers
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            low_cnt <= 16'h0000;
            clr_seen <= 1'b0;
            armed <= 1'b0;
            rd_q <= 1'b0;
            code_ok <= 1'b0;
            last_code <= 8'h00;
        end
        else
        begin
            low_cnt <= scl_oe ? low_cnt + 16'h0001 : 16'h0000;
            clr_seen <= ctl_wr ? (clr_seen | wdata[CTL_FLAG_BIT]
                | !wdata[CTL_EN_BIT]) : (clr_seen & scl_oe);
            armed <= armed | (ctl_wr & wdata[CTL_START_BIT]);
            rd_q <= rd_en && addr == ADDR_STATUS;
            code_ok <= ctl_wr ? 1'b0 : (code_ok | rd_q);
            last_code <= rd_q ? rdata : last_code;
        end
    end

    // a bit's low half is 500; longer means a pause
    sequence s_scl_free;
        !scl_oe [*8];
    endsequence
    sequence s_start_edge;
        $rose(sda_oe) && !scl_oe;
    endsequence
    property p_start_hold;
        s_start_edge |-> s_scl_free;
    endproperty
    a_start_hold: assert property (p_start_hold)
        else $error("scl low after start");
    property p_start_armed;
        s_start_edge |-> armed;
    endproperty
    a_start_armed: assert property (p_start_armed)
        else $error("unrequested start");
    property p_stop_hold;
        $fell(sda_oe) && !scl_oe && !$past(scl_oe) |-> s_scl_free;
    endproperty
    a_stop_hold: assert property (p_stop_hold)
        else $error("scl low after stop");
    property p_pause_release;
        $fell(scl_oe) && low_cnt > 16'd600 |-> clr_seen;
    endproperty
    a_pause_release: assert property (p_pause_release)
        else $error("pause left unreleased");
    property p_rx_hold;
        master_rx_mode && !ctl_wr |=> master_rx_mode && scl_oe;
    endproperty
    a_rx_hold: assert property (p_rx_hold)
        else $error("rx hand-over lost");
    property p_status_stable;
        rd_q && code_ok && last_code != CODE_NO_INFO |-> rdata == last_code;
    endproperty
    a_status_stable: assert property (p_status_stable)
        else $error("status changed");
    property p_rdata_idle;
        !$past(rd_en) |-> rdata == 8'h00;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("stray read data");
    property p_reset_quiet;
        $rose(rst_n) |-> !scl_oe && !sda_oe && !irq && !master_rx_mode;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet)
        else $error("busy after reset");
endmodule : twowire_properties

`default_nettype wire

//--- sim/twowire_slave_model.sv
`timescale 1ns/1ps
`default_nettype none

module twowire_slave_model (
    input wire logic scl,
    input wire logic sda,
    input wire logic ack,
    input wire logic arb,
    output logic sda_pull,
    output logic [7:0] rx_byte
);
    int bit_cnt = 0;
    logic ack_drive = 1'b0;

    // start condition restarts framing
    always @(negedge sda)
        if (scl === 1'b1)
            bit_cnt = -1;
    // msb first, eight data bits per frame
    always @(posedge scl)
        if (bit_cnt >= 0 && bit_cnt < 8)
            rx_byte = {rx_byte[6:0], sda};
    // ack slot covers the ninth low and high phase
    always @(negedge scl)
    begin
        bit_cnt = (bit_cnt == 8) ? 0 : bit_cnt + 1;
        ack_drive = (bit_cnt == 8) && ack;
    end
    // rival master sends 0 in bit one while arb is set
    assign sda_pull = ack_drive || (arb && bit_cnt == 0);
endmodule : twowire_slave_model

`default_nettype wire
